// File: hdl/cb_monitor_pkg.sv
// constants shared by the breaker monitor and its breaker cells
// assumes one 40 MHz clock and a classic wishbone slave port
`default_nettype none

package cb_monitor_pkg;
    localparam int N_CH = 8;
    localparam int N_SLOT = 5;
    localparam int N_CB = 16;
    localparam int DATA_W = 32;
    localparam int ADR_W = 12;
    localparam int CODE_W = 16;
    localparam int SRC_W = 3;
    localparam int CNT_W = 4;

    // slot source encodings
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_CURRENT = 3'h1;
    localparam logic [2:0] SRC_DAC_A = 3'h2;
    localparam logic [2:0] SRC_DAC_B = 3'h3;
    localparam logic [2:0] SRC_VOUT = 3'h4;
    localparam logic [2:0] SRC_TEMP = 3'h5;
    localparam logic [14:0] SRC_RESET = {SRC_TEMP, SRC_DAC_B, SRC_DAC_A, SRC_VOUT, SRC_CURRENT};

    // output selector encodings
    localparam logic [1:0] SEL_OPEN = 2'h0;
    localparam logic [1:0] SEL_A = 2'h1;
    localparam logic [1:0] SEL_B = 2'h2;

    // global register byte addresses
    localparam logic [11:0] OFF_CUR = 12'h000;
    localparam logic [11:0] OFF_STICKY = 12'h004;
    localparam logic [11:0] OFF_RECLOSE = 12'h008;
    localparam logic [11:0] OFF_RETRY = 12'h00C;
    localparam logic [11:0] OFF_IRQ_ST = 12'h010;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
    // channel block: page 1, address bits 7:5 channel, bits 4:2 register
    localparam logic [3:0] PAGE_CH = 4'h1;
    localparam logic [3:0] PAGE_RD = 4'h4;
    localparam logic [2:0] CREG_CFG = 3'h0;
    localparam logic [2:0] CREG_SRC = 3'h1;
    localparam logic [2:0] CREG_LIM0 = 3'h2;
    localparam logic [2:0] CREG_LIM1 = 3'h3;
    localparam logic [2:0] CREG_DAC = 3'h4;

    // channel config fields
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_EN0 = 2;
    localparam int CFG_EN1 = 3;
    localparam int CFG_CNT_LSB = 4;
    localparam int CFG_RETRY = 8;
    localparam int LIM_LO_LSB = 0;
    localparam int LIM_HI_LSB = 16;
    localparam logic [3:0] CNT_MAX = 4'hF;

    // default limits in adc codes: 32 mA and 16 V full scale, 256 codes per degree
    localparam logic signed [15:0] CUR_HI = 16'sh2C00;
    localparam logic signed [15:0] CUR_LO = -16'sh2C00;
    localparam logic signed [15:0] VOLT_HI = 16'sh5800;
    localparam logic signed [15:0] VOLT_LO = -16'sh5800;
    localparam logic signed [15:0] TEMP_HI = 16'sh5500;
    localparam logic signed [15:0] TEMP_LO = -16'sh2800;
    localparam logic signed [15:0] CODE_MAX = 16'sh7FFF;
    localparam logic signed [15:0] CODE_MIN = -16'sh8000;

    // auto retry period
    localparam int CLK_HZ = 40_000_000;
    localparam int RETRY_TIME_MS = 1000;
    localparam int RETRY_CYCLES = CLK_HZ / 1000 * RETRY_TIME_MS;

    // default low and high limit for a slot source, packed {high, low}
    function automatic logic [31:0] default_limits(input logic [2:0] src);
        logic [31:0] lim;
        lim = {CODE_MAX, CODE_MIN};
        case (src)
            SRC_CURRENT: lim = {CUR_HI, CUR_LO};
            SRC_DAC_A, SRC_DAC_B, SRC_VOUT: lim = {VOLT_HI, VOLT_LO};
            SRC_TEMP: lim = {TEMP_HI, TEMP_LO};
            default: lim = {CODE_MAX, CODE_MIN};
        endcase
        return lim;
    endfunction
endpackage

`default_nettype wire

// File: hdl/breaker_cell.sv
// one circuit breaker: window check, consecutive run count, trip and re-close
// assumes readings arrive as single-cycle strobes on the same clock
`default_nettype none

module breaker_cell (
    input wire logic clock,
    input wire logic resetn,
    input wire logic enable,
    input wire logic [cb_monitor_pkg::CNT_W-1:0] run_limit,
    input wire logic signed [cb_monitor_pkg::CODE_W-1:0] low_limit,
    input wire logic signed [cb_monitor_pkg::CODE_W-1:0] high_limit,
    input wire logic sample_valid,
    input wire logic signed [cb_monitor_pkg::CODE_W-1:0] sample,
    input wire logic reclose,
    input wire logic retry_tick,
    output logic tripped,
    output logic trip_event
);
    import cb_monitor_pkg::*;

    logic [CNT_W-1:0] run_q;
    logic ok_q;
    logic violation;
    logic fire;

    // equal to a limit is still in range
    assign violation = (sample < low_limit) || (sample > high_limit);
    // run_q counts earlier violations, so a limit of 0 fires on the first one
    assign fire = enable && sample_valid && violation && (run_q >= run_limit);

    // consecutive violation counter, cleared by any in-range reading
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            run_q <= '0;
        end else if (!enable || reclose) begin
            run_q <= '0;
        end else if (sample_valid) begin
            if (!violation) begin
                run_q <= '0;
            end else if (run_q != CNT_MAX) begin
                run_q <= run_q + 4'h1;
            end
        end
    end

    // last reading back inside the window allows an automatic re-close
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ok_q <= 1'b1;
        end else if (sample_valid) begin
            ok_q <= !violation;
        end
    end

    // trip state; a trip in the same cycle as a re-close wins
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tripped <= 1'b0;
            trip_event <= 1'b0;
        end else begin
            trip_event <= fire && !tripped;
            if (!enable) begin
                tripped <= 1'b0;
            end else if (fire) begin
                tripped <= 1'b1;
            end else if (reclose) begin
                tripped <= 1'b0;
            end else if (retry_tick && ok_q) begin
                tripped <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// File: hdl/output_breaker_monitor.sv
// breaker monitor for eight protected analog outputs, two breakers each
// assumes a classic wishbone master and an adc sequencer on the same clock
`default_nettype none

module output_breaker_monitor #(
    parameter bit DUAL_DAC = 1'b1,
    parameter int unsigned RETRY_PERIOD = cb_monitor_pkg::RETRY_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [cb_monitor_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [cb_monitor_pkg::DATA_W-1:0] wb_dat_i,
    output logic [cb_monitor_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic adc_valid,
    input wire logic [5:0] adc_index,
    input wire logic signed [cb_monitor_pkg::CODE_W-1:0] adc_data,
    output logic [cb_monitor_pkg::N_CH*cb_monitor_pkg::N_SLOT*cb_monitor_pkg::SRC_W-1:0] slot_src,
    output logic [cb_monitor_pkg::N_CH*cb_monitor_pkg::CODE_W-1:0] dac_code,
    output logic [cb_monitor_pkg::N_CH-1:0] dac_load,
    output logic [2*cb_monitor_pkg::N_CH-1:0] path_sel,
    output logic irq
);
    import cb_monitor_pkg::*;

    // bus decode
    logic access;
    logic wr;
    logic rd;
    logic [11:0] adr_w;
    logic [3:0] page;
    logic [2:0] ch;
    logic [2:0] creg;
    logic [31:0] rdata_d;
    logic [31:0] wd;

    // configuration and state
    logic [2*N_CH-1:0] sel_q;
    logic [N_CB-1:0] cb_en_q;
    logic [N_CH*CNT_W-1:0] cnt_q;
    logic [N_CH-1:0] retry_en_q;
    logic signed [CODE_W-1:0] lim_lo_q [N_CB];
    logic signed [CODE_W-1:0] lim_hi_q [N_CB];
    logic signed [CODE_W-1:0] reading_q [64];
    logic [N_CB-1:0] tripped;
    logic [N_CB-1:0] trip_event;
    logic [N_CB-1:0] sticky_q;
    logic [N_CB-1:0] irq_st_q;
    logic [N_CB-1:0] irq_mask_q;
    logic [N_CB-1:0] reclose_q;
    logic [31:0] retry_period_q;
    logic [31:0] retry_cnt_q;
    logic retry_tick_q;

    // a request is taken once; ack follows one cycle later
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = access && wb_we_i;
    assign rd = access && !wb_we_i;
    assign adr_w = {wb_adr_i[11:2], 2'b00};
    assign page = wb_adr_i[11:8];
    assign ch = wb_adr_i[7:5];
    assign creg = wb_adr_i[4:2];

    // byte lanes merge write data over the current register value
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wd[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : rdata_d[b*8 +: 8];
        end
    end

    // read mux, also the base for byte-lane merges
    always_comb begin
        rdata_d = '0;
        if (page == PAGE_CH) begin
            case (creg)
                CREG_CFG: begin
                    rdata_d[CFG_SEL_LSB +: 2] = sel_q[ch*2 +: 2];
                    rdata_d[CFG_EN0] = cb_en_q[ch*2];
                    rdata_d[CFG_EN1] = cb_en_q[ch*2+1];
                    rdata_d[CFG_CNT_LSB +: CNT_W] = cnt_q[ch*CNT_W +: CNT_W];
                    rdata_d[CFG_RETRY] = retry_en_q[ch];
                end
                CREG_SRC: rdata_d[14:0] = slot_src[ch*15 +: 15];
                CREG_LIM0: rdata_d = {lim_hi_q[ch*2], lim_lo_q[ch*2]};
                CREG_LIM1: rdata_d = {lim_hi_q[ch*2+1], lim_lo_q[ch*2+1]};
                CREG_DAC: rdata_d[15:0] = dac_code[ch*CODE_W +: CODE_W];
                default: rdata_d = '0;
            endcase
        end else if (page == PAGE_RD) begin
            // only slots 0..4 of each group of eight exist
            if (wb_adr_i[4:2] <= 3'h4) begin
                rdata_d[15:0] = reading_q[wb_adr_i[7:2]];
            end
        end else begin
            case (adr_w)
                OFF_CUR: rdata_d[15:0] = tripped;
                OFF_STICKY: rdata_d[15:0] = sticky_q;
                OFF_RETRY: rdata_d = retry_period_q;
                OFF_IRQ_ST: rdata_d[15:0] = irq_st_q;
                OFF_IRQ_MASK: rdata_d[15:0] = irq_mask_q;
                default: rdata_d = '0;
            endcase
        end
    end

    // wishbone answer: registered ack and data, unmapped reads return zero
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= access;
            if (rd) begin
                wb_dat_o <= rdata_d;
            end
        end
    end

    // channel configuration writes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sel_q <= '0;
            cb_en_q <= '0;
            cnt_q <= '0;
            retry_en_q <= '0;
            slot_src <= {N_CH{SRC_RESET}};
            for (int i = 0; i < N_CB; i++) begin
                lim_lo_q[i] <= (i % 2 == 1) ? VOLT_LO : CUR_LO;
                lim_hi_q[i] <= (i % 2 == 1) ? VOLT_HI : CUR_HI;
            end
        end else if (wr && page == PAGE_CH) begin
            case (creg)
                CREG_CFG: begin
                    // the spare code, and dac b when DUAL_DAC is 0, fall back to disconnected
                    if (wd[1:0] == SEL_A || (wd[1:0] == SEL_B && DUAL_DAC)) begin
                        sel_q[ch*2 +: 2] <= wd[1:0];
                    end else begin
                        sel_q[ch*2 +: 2] <= SEL_OPEN;
                    end
                    cb_en_q[ch*2] <= wd[CFG_EN0];
                    cb_en_q[ch*2+1] <= wd[CFG_EN1];
                    cnt_q[ch*CNT_W +: CNT_W] <= wd[CFG_CNT_LSB +: CNT_W];
                    retry_en_q[ch] <= wd[CFG_RETRY];
                end
                CREG_SRC: begin
                    // any source write reloads both breakers' default windows from the slot 0 and slot 1 sources
                    slot_src[ch*15 +: 15] <= wd[14:0];
                    {lim_hi_q[ch*2], lim_lo_q[ch*2]} <= default_limits(wd[2:0]);
                    {lim_hi_q[ch*2+1], lim_lo_q[ch*2+1]} <= default_limits(wd[5:3]);
                end
                CREG_LIM0: begin
                    lim_lo_q[ch*2] <= wd[LIM_LO_LSB +: CODE_W];
                    lim_hi_q[ch*2] <= wd[LIM_HI_LSB +: CODE_W];
                end
                CREG_LIM1: begin
                    lim_lo_q[ch*2+1] <= wd[LIM_LO_LSB +: CODE_W];
                    lim_hi_q[ch*2+1] <= wd[LIM_HI_LSB +: CODE_W];
                end
                default: begin
                end
            endcase
        end
    end

    // raw converter codes, each write applied once with a load strobe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dac_code <= '0;
            dac_load <= '0;
        end else begin
            dac_load <= '0;
            if (wr && page == PAGE_CH && creg == CREG_DAC) begin
                dac_code[ch*CODE_W +: CODE_W] <= wd[15:0];
                dac_load[ch] <= 1'b1;
            end
        end
    end

    // latest reading per analog input index
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 64; i++) begin
                reading_q[i] <= '0;
            end
        end else if (adc_valid) begin
            reading_q[adc_index] <= adc_data;
        end
    end

    // manual re-close strobe, one cycle per written mask
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reclose_q <= '0;
        end else if (wr && adr_w == OFF_RECLOSE && page != PAGE_CH && page != PAGE_RD) begin
            reclose_q <= wb_dat_i[15:0] & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        end else begin
            reclose_q <= '0;
        end
    end

    // auto-retry period counter
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            retry_period_q <= 32'(RETRY_PERIOD);
            retry_cnt_q <= '0;
            retry_tick_q <= 1'b0;
        end else begin
            if (wr && adr_w == OFF_RETRY && page == 4'h0) begin
                retry_period_q <= wd;
            end
            retry_tick_q <= 1'b0;
            if (retry_cnt_q + 32'h0000_0001 >= retry_period_q) begin
                retry_cnt_q <= '0;
                retry_tick_q <= 1'b1;
            end else begin
                retry_cnt_q <= retry_cnt_q + 32'h0000_0001;
            end
        end
    end

    // the breakers: even index watches slot 0, odd index slot 1
    for (genvar g = 0; g < N_CB; g++) begin : gen_cb
        breaker_cell u_cell (
            .clock(clock),
            .resetn(resetn),
            .enable(cb_en_q[g]),
            .run_limit(cnt_q[(g/2)*CNT_W +: CNT_W]),
            .low_limit(lim_lo_q[g]),
            .high_limit(lim_hi_q[g]),
            .sample_valid(adc_valid && adc_index == 6'((g/2)*8 + g%2)
                && slot_src[(g/2)*15 + (g%2)*3 +: 3] != SRC_NONE),
            .sample(adc_data),
            .reclose(reclose_q[g]),
            .retry_tick(retry_tick_q && retry_en_q[g/2]),
            .tripped(tripped[g]),
            .trip_event(trip_event[g])
        );
    end

    // sticky mask: read clears, a trip in the same cycle wins
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sticky_q <= '0;
        end else begin
            sticky_q <= ((rd && adr_w == OFF_STICKY && page == 4'h0) ? '0 : sticky_q) | trip_event;
        end
    end

    // interrupt status (write one to clear), mask and level output
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_st_q <= '0;
            irq_mask_q <= '0;
            irq <= 1'b0;
        end else begin
            if (wr && adr_w == OFF_IRQ_ST && page == 4'h0) begin
                irq_st_q <= (irq_st_q & ~wd[15:0]) | trip_event;
            end else begin
                irq_st_q <= irq_st_q | trip_event;
            end
            if (wr && adr_w == OFF_IRQ_MASK && page == 4'h0) begin
                irq_mask_q <= wd[15:0];
            end
            irq <= |(irq_st_q & irq_mask_q);
        end
    end

    // output path: selected converter unless either breaker is open
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            path_sel <= '0;
        end else begin
            for (int c = 0; c < N_CH; c++) begin
                path_sel[c*2 +: 2] <= (tripped[c*2] || tripped[c*2+1]) ? SEL_OPEN : sel_q[c*2 +: 2];
            end
        end
    end
endmodule

`default_nettype wire

// File: tb/obm_monitor.sv
// checker for the breaker monitor: bus timing and what may move its outputs
// assumes it is bound to every output_breaker_monitor instance by the bind below
`default_nettype none

module obm_monitor (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [cb_monitor_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [cb_monitor_pkg::DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic adc_valid,
    input wire logic [cb_monitor_pkg::N_CH*cb_monitor_pkg::N_SLOT*cb_monitor_pkg::SRC_W-1:0] slot_src,
    input wire logic [cb_monitor_pkg::N_CH*cb_monitor_pkg::CODE_W-1:0] dac_code,
    input wire logic [cb_monitor_pkg::N_CH-1:0] dac_load,
    input wire logic [2*cb_monitor_pkg::N_CH-1:0] path_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    import cb_monitor_pkg::*;
    logic take;
    logic wtake;
    logic rtake;
    logic dtake;
    logic [N_CH-1:0] sel3;

    // request qualifiers seen at the slave
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wtake = take && wb_we_i;
    assign rtake = take && !wb_we_i;
    assign dtake = wtake && wb_adr_i[11:8] == PAGE_CH && wb_adr_i[4:2] == CREG_DAC;

    // flags a selector field holding the unused code
    always_comb begin
        for (int i = 0; i < N_CH; i++) begin
            sel3[i] = &path_sel[2*i+:2];
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
    a_ack_after_take: assert property (take |=> wb_ack_o)
        else $error("request taken without ack next cycle");
    a_ack_no_cause: assert property (!take |=> !wb_ack_o)
        else $error("ack without a taken request");
    a_rdata_hold: assert property (!$stable(wb_dat_o) |-> $past(rtake))
        else $error("read data moved without a read");
    a_src_cause: assert property (!$stable(slot_src) |-> $past(wtake))
        else $error("slot sources moved without a write");
    a_code_cause: assert property (!$stable(dac_code) |-> $past(dtake))
        else $error("converter code moved without a code write");
    a_load_cause: assert property (|dac_load |-> $past(dtake) || $past(dtake, 2))
        else $error("load pulse without a code write");
    a_load_follows: assert property (dtake |-> ##[1:2] (|dac_load))
        else $error("code write gave no load pulse");
    a_path_cause: assert property (|($past(path_sel) & ~path_sel) |->
        $past(wtake) || $past(wtake, 2) || $past(adc_valid, 2) || $past(adc_valid, 3))
        else $error("output path opened without a reading or write");
    a_sel_legal: assert property (sel3 == '0)
        else $error("selector holds an unused code");
endmodule

bind output_breaker_monitor obm_monitor u_mon (.clock, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .adc_valid, .slot_src, .dac_code, .dac_load, .path_sel);

`default_nettype wire

// File: tb/adc_sequencer.sv
// diagnostic converter sequencer model: one reading strobe per request
// assumes requests come from the bench on the same clock
`default_nettype none

module adc_sequencer (
    input wire logic clock,
    input wire logic resetn,
    input wire logic go,
    input wire logic [5:0] go_index,
    input wire logic [15:0] go_data,
    output logic adc_valid,
    output logic [5:0] adc_index,
    output logic [15:0] adc_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // strobe for one cycle; outside it index and data are scrambled
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            adc_valid <= 1'b0;
            adc_index <= 6'h00;
            adc_data <= 16'h0000;
        end else begin
            adc_valid <= go;
            adc_index <= go ? go_index : ~adc_index;
            adc_data <= go ? go_data : ~adc_data;
        end
    end
endmodule

`default_nettype wire

// File: tb/output_breaker_monitor_bench.sv
// self-checking bench: wishbone host tasks, reading feeder, queued read checks
// assumes the package and design are compiled first; retry period shortened to 20
`default_nettype none

module output_breaker_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import cb_monitor_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = '0;
    logic go = 1'b0;
    logic [5:0] gidx = '0;
    logic [15:0] gdat = '0;
    logic [31:0] rdat;
    logic ack;
    logic aval;
    logic [5:0] aidx;
    logic [15:0] adat;
    logic [N_CH*N_SLOT*SRC_W-1:0] src;
    logic [N_CH*CODE_W-1:0] code;
    logic [N_CH-1:0] load;
    logic [2*N_CH-1:0] path;
    logic irq;
    logic [31:0] lf = 32'haefc;
    logic [31:0] expq[$];
    int bad_count = 0;
    int compares = 0;
    int runs[3] = '{0, 3, 15};

    output_breaker_monitor #(.DUAL_DAC(1'b1), .RETRY_PERIOD(20)) u_dut (.clock(clock), .resetn(resetn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .adc_valid(aval), .adc_index(aidx), .adc_data(adat),
        .slot_src(src), .dac_code(code), .dac_load(load), .path_sel(path), .irq(irq));
    adc_sequencer u_adc (.clock(clock), .resetn(resetn), .go(go), .go_index(gidx), .go_data(gdat),
        .adc_valid(aval), .adc_index(aidx), .adc_data(adat));

    // 40 MHz clock
    initial begin
        forever #12.5 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [11:0] ca(input int n, input logic [2:0] r);
        return {PAGE_CH, 3'(n), r, 2'h0};
    endfunction

    // default window {high, low} for a slot source in converter codes
    function automatic logic [31:0] dlim(input int s);
        case (s)
            1: return 32'h2C00_D400;
            2, 3, 4: return 32'h5800_A800;
            5: return 32'h5500_D800;
            default: return 32'h7FFF_8000;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one classic cycle: hold until ack is sampled, then release
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (ack === 1'b1) break;
        end
        if (i == 50) begin
            bad_count++;
            wrap_up();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic sample(input logic [5:0] i, input logic [15:0] d);
        @(posedge clock);
        go <= 1'b1;
        gidx <= i;
        gdat <= d;
        @(posedge clock);
        go <= 1'b0;
    endtask

    // read answers are matched against the oldest queued note
    always @(posedge clock) begin
        if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
            check(rdat, (expq.size() > 0) ? expq.pop_front() : 32'hDEAD_BEEF);
        end
        // a converter code write shows one load pulse on its own channel while ack stands
        if (ack === 1'b1 && cyc === 1'b1 && we === 1'b1 && adr[11:8] == PAGE_CH && adr[4:2] == CREG_DAC) begin
            check(load, 8'h01 << adr[7:5]);
        end
    end

    // main sequence
    initial begin
        idle(2);
        resetn <= 1'b1;
        for (int n = 0; n < N_CH; n++) check(src[n*15+:15], 15'h56A1);
        check({irq, path}, 32'h0000_0000);
        rd(OFF_CUR, 32'h0000_0000);
        rd(OFF_RETRY, 32'h0000_0014);
        rd(ca(0, CREG_LIM0), 32'h2C00_D400);
        rd(ca(0, CREG_LIM1), 32'h5800_A800);
        bus(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        rd(12'h0FC, 32'h0000_0000);
        for (int n = 0; n < N_CH; n++) begin
            lf = lfsr(lf);
            bus(1'b1, ca(n, CREG_DAC), lf);
            check(code[n*16+:16], lf[15:0]);
        end
        for (int s = 0; s <= 5; s++) begin
            bus(1'b1, ca(1, CREG_SRC), {17'h0, {5{3'(s)}}});
            check(src[15+:15], {5{3'(s)}});
            rd(ca(1, CREG_LIM0), dlim(s));
        end
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, ca(0, CREG_CFG), 32'(s));
            idle(2);
            check(path[1:0], (s == 3) ? 2'h0 : 2'(s));
        end
        bus(1'b1, ca(2, CREG_LIM0), 32'h0064_FF9C);
        foreach (runs[j]) begin
            bus(1'b1, ca(2, CREG_CFG), 32'h0000_0005 | (runs[j] << 4));
            repeat (runs[j]) sample(6'h10, 16'h0065);
            sample(6'h10, 16'h0064);
            repeat (runs[j]) sample(6'h10, 16'hFF9B);
            idle(3);
            check(path[5:4], 2'h1);
            sample(6'h10, 16'hFF9B);
            idle(3);
            check(path[5:4], 2'h0);
            rd(OFF_CUR, 32'h0000_0010);
            rd(OFF_STICKY, 32'h0000_0010);
            rd(OFF_STICKY, 32'h0000_0000);
            bus(1'b1, OFF_RECLOSE, 32'h0000_0010);
            rd(OFF_CUR, 32'h0000_0000);
        end
        check(irq, 1'b0);
        rd(OFF_IRQ_ST, 32'h0000_0010);
        bus(1'b1, OFF_IRQ_MASK, 32'h0000_0010);
        idle(2);
        check(irq, 1'b1);
        bus(1'b1, OFF_IRQ_ST, 32'h0000_0010);
        idle(2);
        check(irq, 1'b0);
        bus(1'b1, ca(2, CREG_CFG), 32'h0000_000D);
        sample(6'h11, 16'h7000);
        rd(OFF_CUR, 32'h0000_0020);
        sample(6'h10, 16'hFF9B);
        rd(OFF_CUR, 32'h0000_0030);
        bus(1'b1, OFF_RECLOSE, 32'h0000_0010);
        rd(OFF_CUR, 32'h0000_0020);
        bus(1'b1, OFF_RECLOSE, 32'h0000_0020);
        rd(OFF_CUR, 32'h0000_0000);
        rd({PAGE_RD, 6'h11, 2'h0}, 32'h0000_7000);
        rd({PAGE_RD, 6'h15, 2'h0}, 32'h0000_0000);
        bus(1'b1, ca(2, CREG_CFG), 32'h0000_0001);
        sample(6'h10, 16'hFF9B);
        idle(3);
        check(path[5:4], 2'h1);
        rd(OFF_CUR, 32'h0000_0000);
        bus(1'b1, ca(2, CREG_CFG), 32'h0000_0105);
        sample(6'h10, 16'hFF9B);
        idle(45);
        check(path[5:4], 2'h0);
        lf = lfsr(lf);
        // random reading kept inside the 100 code window so the retry may re-close
        sample(6'h10, {10'h000, lf[5:0]});
        for (int i = 0; i < 100 && path[5:4] !== 2'h1; i++) idle(1);
        check(path[5:4], 2'h1);
        wrap_up();
    end
endmodule

`default_nettype wire
